// ### design/ebha_pkg.sv
package ebha_pkg;

   // synchroniser depth for the asynchronous arbitration and halt inputs
   localparam int SYNC_STAGES = 2;

   // transfer acknowledge encodings (active low pair)
   localparam logic [1:0] ACK_NONE = 2'h0_3;
   localparam logic [1:0] ACK_BYTE_PORT = 2'h0_2;

   // transfer size encodings
   localparam logic [1:0] SIZE_LONG = 2'h0_0;
   localparam logic [1:0] SIZE_BYTE = 2'h0_1;
   localparam logic [1:0] SIZE_WORD = 2'h0_2;

   // show cycle setting that forbids handing the bus away
   localparam logic [1:0] SHOW_NO_GRANT = 2'h0_1;

   // level driven onto the open-drain halt line during a double fault
   localparam logic HALT_DRIVE_LEVEL = 1'b0;

   // reset values (inactive) of synchronised active-low inputs and of the retimed active-high grant
   localparam logic SYNC_RESET_LEVEL = 1'b1;
   localparam logic GRANT_RESET_LEVEL = 1'b0;

   typedef enum logic [1:0] {
      B_IDLE = 2'b00,
      B_CYCLE = 2'b01,
      B_RETRY = 2'b10
   } ebha_bus_state_t;

   typedef enum logic [1:0] {
      AR_MASTER = 2'b00,
      AR_GRANT = 2'b01,
      AR_OWNED = 2'b10,
      AR_REGRANT = 2'b11
   } ebha_arb_state_t;

   typedef struct packed {
      ebha_bus_state_t bState;
      ebha_arb_state_t arState;
      logic opOpen;
      logic dblFault;
      logic cycleStart;
      logic cycleDone;
      logic busErrExc;
      logic grant;
   } ebha_main_state_t;

endpackage

// ### design/ebha_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ebha_sync
   import ebha_pkg::*;
#(
   parameter int WIDTH = 1,
   parameter int STAGES = SYNC_STAGES
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);

   if (WIDTH < 1 || STAGES != 2) begin : g_check
      $error("ebha_sync supports WIDTH >= 1 and exactly two stages");
   end

   typedef struct packed {
      logic [WIDTH-1:0] first;
      logic [WIDTH-1:0] second;
   } ebha_sync_state_t;

   ebha_sync_state_t st;
   ebha_sync_state_t next_st;

   // first stage feeds only the second stage
   always_comb begin
      next_st.first = din;
      next_st.second = st.first;
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         st <= {(2 * WIDTH){SYNC_RESET_LEVEL}};
      end else begin
         st <= next_st;
      end
   end

   assign dout = st.second;

endmodule
`default_nettype wire

// ### design/ebha_fall_stage.sv
`timescale 1ns/1ps
`default_nettype none
module ebha_fall_stage
   import ebha_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic din,
   output logic dout
);

   typedef struct packed {
      logic level;
   } ebha_fall_state_t;

   ebha_fall_state_t st;
   ebha_fall_state_t next_st;

   always_comb begin
      next_st.level = din;
   end

   // retimed on the falling edge so the pin moves half a clock after the state
   always_ff @(negedge ref_clk) begin
      if (reset) begin
         st.level <= GRANT_RESET_LEVEL;
      end else begin
         st <= next_st;
      end
   end

   assign dout = st.level;

endmodule
`default_nettype wire

// ### design/ebha_bus_halt_arbiter.sv
// Behaviour
// - halt without bus fault stops new external cycles at the next cycle boundary
// - halt alone never ends a running cycle; it still needs acknowledge
// - releasing then reasserting halt lets exactly one more cycle run
// - halt blocks only external cycles; internal execution keeps running
// - bus fault while halted means retry, not bus error exception
// - halted: data bus floats, strobes driven inactive, address lines hold
// - granted away: address and control float; driven again when bus returns
// - no interrupt acceptance while halted
// - double fault only for errors during error or reset exception processing
// - double fault halts, drives halt line low, only reset restarts
// - retried cycle is no bus error; retry repeats while requested
// - arbitration order: request, grant, grant acknowledge
// - grant only at operand end and never during a locked cycle
// - multi-cycle operand: grant waits for last cycle by size and acknowledge
// - show cycle setting 01 blocks new grants only; a regrant while the bus is owned ignores it
// - grant drops after acknowledge changes, reasserts if requests remain
// - requests honoured when running, halted between cycles, or double faulted; not while a halted cycle waits to retry
// - bus released only after the started cycle completes, ahead of any new cycle
// - request withdrawn before acknowledge: device stays master
// - external mastership ends exactly when grant acknowledge negates
// - request held after acknowledge counts as a new requester
// - request and acknowledge inputs synchronised in two clocks
// - grant pin changes on the falling edge after the state change
// - request ignored throughout a locked read-modify-write sequence
`timescale 1ns/1ps
`default_nettype none
module ebha_bus_halt_arbiter
   import ebha_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic haltIn_n,
   output logic haltOut,
   output logic haltOe_n,
   input wire logic bus_fault_in,
   input wire logic [1:0] transfer_ack_n,
   input wire logic [1:0] transfer_size,
   input wire logic locked_cycle_n,
   input wire logic [1:0] show_cycle_enable,
   input wire logic bus_request_n,
   input wire logic grant_ack_n,
   output logic bus_grant_n,
   input wire logic cycleReq,
   input wire logic excProcActive,
   input wire logic addrErrPulse,
   output logic cycleStart,
   output logic cycleDone,
   output logic busErrExc,
   output logic retryActive,
   output logic strobeEnable,
   output logic strobeOe_n,
   output logic dataOe_n,
   output logic addrOe_n,
   output logic intAcceptEn,
   output logic halted,
   output logic doubleFault
);

   ebha_main_state_t st;
   ebha_main_state_t next_st;

   logic [2:0] syncIn;
   logic [2:0] syncOut;
   logic reqS;
   logic ackS;
   logic haltS;
   logic grantPin;
   logic ackSeen;
   logic lastCycle;
   logic canGrant;
   logic grantNow;
   logic extOwned;

   assign syncIn = {haltIn_n, grant_ack_n, bus_request_n};

   ebha_sync #(
      .WIDTH(3),
      .STAGES(SYNC_STAGES)
   ) u_sync (
      .ref_clk(ref_clk),
      .reset(reset),
      .din(syncIn),
      .dout(syncOut)
   );

   // request is dropped while the locked sequence runs
   assign reqS = !syncOut[0] && locked_cycle_n;
   assign ackS = !syncOut[1];
   assign haltS = !syncOut[2];

   assign ackSeen = (transfer_ack_n != ACK_NONE);

   // the operand ends with this acknowledge only when the port covers what is left
   assign lastCycle = (transfer_size == SIZE_BYTE)
      || (transfer_size == SIZE_WORD && transfer_ack_n != ACK_BYTE_PORT);

   // grant only between operands, outside locked cycles and show setting 01
   assign canGrant = (st.bState == B_IDLE) && !st.opOpen && locked_cycle_n
      && (show_cycle_enable != SHOW_NO_GRANT);

   // arbitration is evaluated regardless of halt or double fault
   assign grantNow = (st.arState == AR_MASTER) && reqS && canGrant;

   always_comb begin
      next_st = st;
      next_st.cycleStart = 1'b0;
      next_st.cycleDone = 1'b0;
      next_st.busErrExc = 1'b0;

      case (st.bState)
         B_IDLE: begin
            // halt and double fault gate only the start of external cycles
            if (cycleReq && !haltS && !st.dblFault && st.arState == AR_MASTER && !grantNow) begin
               next_st.bState = B_CYCLE;
               next_st.opOpen = 1'b1;
               next_st.cycleStart = 1'b1;
            end
         end
         B_CYCLE: begin
            if (bus_fault_in && haltS) begin
               next_st.bState = B_RETRY;
            end else if (bus_fault_in) begin
               next_st.bState = B_IDLE;
               next_st.opOpen = 1'b0;
               next_st.busErrExc = 1'b1;
               if (excProcActive) begin
                  next_st.dblFault = 1'b1;
               end
            end else if (ackSeen) begin
               // halt has no say here: only acknowledge ends the cycle
               next_st.bState = B_IDLE;
               next_st.cycleDone = 1'b1;
               if (lastCycle) begin
                  next_st.opOpen = 1'b0;
               end
            end
         end
         B_RETRY: begin
            // same access repeats once fault and halt are both released, unless a double fault is set
            if (!bus_fault_in && !haltS && !st.dblFault) begin
               next_st.bState = B_CYCLE;
               next_st.cycleStart = 1'b1;
            end
         end
         default: begin
            next_st.bState = B_IDLE;
         end
      endcase

      if (addrErrPulse && excProcActive) begin
         next_st.dblFault = 1'b1;
      end

      case (st.arState)
         AR_MASTER: begin
            if (grantNow) begin
               next_st.arState = AR_GRANT;
            end
         end
         AR_GRANT: begin
            if (ackS) begin
               next_st.arState = AR_OWNED;
            end else if (!reqS) begin
               next_st.arState = AR_MASTER;
            end
         end
         AR_OWNED: begin
            if (!ackS) begin
               next_st.arState = reqS ? AR_GRANT : AR_MASTER;
            end else if (reqS) begin
               next_st.arState = AR_REGRANT;
            end
         end
         AR_REGRANT: begin
            if (!ackS) begin
               next_st.arState = AR_GRANT;
            end else if (!reqS) begin
               next_st.arState = AR_OWNED;
            end
         end
         default: begin
            next_st.arState = AR_MASTER;
         end
      endcase

      next_st.grant = (next_st.arState == AR_GRANT) || (next_st.arState == AR_REGRANT);
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         st.bState <= B_IDLE;
         st.arState <= AR_MASTER;
         st.opOpen <= 1'b0;
         st.dblFault <= 1'b0;
         st.cycleStart <= 1'b0;
         st.cycleDone <= 1'b0;
         st.busErrExc <= 1'b0;
         st.grant <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   ebha_fall_stage u_grant_out (
      .ref_clk(ref_clk),
      .reset(reset),
      .din(st.grant),
      .dout(grantPin)
   );

   assign bus_grant_n = !grantPin;

   // double fault pulls the shared halt line low until reset
   assign haltOut = HALT_DRIVE_LEVEL;
   assign haltOe_n = !st.dblFault;

   assign cycleStart = st.cycleStart;
   assign cycleDone = st.cycleDone;
   assign busErrExc = st.busErrExc;
   assign retryActive = (st.bState == B_RETRY);
   assign doubleFault = st.dblFault;

   assign halted = st.dblFault || (st.bState == B_RETRY) || (st.bState == B_IDLE && haltS);
   assign intAcceptEn = !halted;

   // outside a cycle the strobes are inactive, driven unless the bus is granted away, and data floats
   assign strobeEnable = (st.bState == B_CYCLE);
   assign dataOe_n = (st.bState != B_CYCLE);

   // address lines keep their last value; they float from bus grant until the bus returns, while no cycle runs
   assign extOwned = (st.arState != AR_MASTER) && (st.bState == B_IDLE);
   assign addrOe_n = extOwned;
   assign strobeOe_n = extOwned;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   sequence s_fault_halted;
      st.bState == B_CYCLE && bus_fault_in && haltS;
   endsequence

   sequence s_retry_held;
      st.bState == B_RETRY && !busErrExc;
   endsequence

   property p_start_gated;
      cycleStart && $past(st.bState) == B_IDLE |-> !$past(haltS) && !$past(st.dblFault);
   endproperty
   a_start_gated: assert property (p_start_gated) else $error("cycle started while halted");

   property p_halt_no_end;
      st.bState == B_CYCLE && !ackSeen && !bus_fault_in |=> st.bState == B_CYCLE && !cycleDone;
   endproperty
   a_halt_no_end: assert property (p_halt_no_end) else $error("cycle ended without acknowledge");

   property p_retry;
      s_fault_halted |=> s_retry_held ##1 !busErrExc;
   endproperty
   a_retry: assert property (p_retry) else $error("fault while halted did not retry");

   property p_halted_float;
      st.bState != B_CYCLE |-> dataOe_n && !strobeEnable;
   endproperty
   a_halted_float: assert property (p_halted_float) else $error("data or strobes active outside cycle");

   property p_owned_float;
      st.arState == AR_OWNED && st.bState == B_IDLE |-> addrOe_n && strobeOe_n;
   endproperty
   a_owned_float: assert property (p_owned_float) else $error("address driven while bus granted away");

   property p_no_int;
      halted |-> !intAcceptEn;
   endproperty
   a_no_int: assert property (p_no_int) else $error("interrupt accepted while halted");

   property p_dbl_sticky;
      doubleFault |=> doubleFault && !haltOe_n && !cycleStart;
   endproperty
   a_dbl_sticky: assert property (p_dbl_sticky) else $error("double fault released without reset");

   property p_show_block;
      st.arState == AR_MASTER && show_cycle_enable == SHOW_NO_GRANT |=> st.arState == AR_MASTER;
   endproperty
   a_show_block: assert property (p_show_block) else $error("grant given with show setting 01");

   property p_lock_block;
      st.arState == AR_MASTER && !locked_cycle_n |=> st.arState == AR_MASTER;
   endproperty
   a_lock_block: assert property (p_lock_block) else $error("grant given during locked cycle");

   property p_withdraw;
      st.arState == AR_GRANT && !reqS && !ackS |=> st.arState == AR_MASTER;
   endproperty
   a_withdraw: assert property (p_withdraw) else $error("withdrawn request did not return bus");

   property p_grant_fall;
      ($rose(st.grant) |-> !bus_grant_n) and ($fell(st.grant) |-> bus_grant_n);
   endproperty
   a_grant_fall: assert property (p_grant_fall) else $error("grant pin not retimed by falling edge");

   property p_sync_depth;
      !bus_request_n [*3] |-> !syncOut[0];
   endproperty
   a_sync_depth: assert property (p_sync_depth) else $error("request not seen within two clocks");

   property p_ack_end;
      st.arState == AR_OWNED && !ackS |=> st.arState != AR_OWNED;
   endproperty
   a_ack_end: assert property (p_ack_end) else $error("mastership kept after acknowledge dropped");

   property p_grant_idle;
      $rose(st.grant) && $past(st.arState) == AR_MASTER |-> $past(st.bState) == B_IDLE && !$past(st.opOpen);
   endproperty
   a_grant_idle: assert property (p_grant_idle) else $error("grant during a cycle or open operand");

   property p_dbl_cause;
      $rose(doubleFault) |-> $past(excProcActive);
   endproperty
   a_dbl_cause: assert property (p_dbl_cause) else $error("double fault outside exception processing");

   property p_reset_state;
      $fell(reset) |-> bus_grant_n && !doubleFault && !halted && st.arState == AR_MASTER;
   endproperty
   a_reset_state: assert property (p_reset_state) else $error("arbiter not idle master after reset");

   property p_done_ack;
      cycleDone |-> $past(ackSeen) && !$past(bus_fault_in);
   endproperty
   a_done_ack: assert property (p_done_ack) else $error("cycle done without acknowledge");

   property p_regrant;
      st.arState == AR_OWNED && ackS && reqS |=> st.grant;
   endproperty
   a_regrant: assert property (p_regrant) else $error("held request not granted again");

   property p_long_open;
      st.bState == B_CYCLE && ackSeen && !bus_fault_in && transfer_size == SIZE_LONG |=> st.opOpen;
   endproperty
   a_long_open: assert property (p_long_open) else $error("long operand closed after one cycle");

endmodule
`default_nettype wire

// ### tb/ebha_ext_master.sv
`timescale 1ns/1ps
`default_nettype none
module ebha_ext_master #(
   parameter int HOLD = 12
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic go,
   input wire logic stay,
   input wire logic bus_grant_n,
   output logic bus_request_n = 1'b1,
   output logic grant_ack_n = 1'b1
);
   int cnt = 0;
   logic served = 1'b0;
   logic goQ = 1'b0;
   logic stayQ = 1'b0;
   // controls are taken at the rising edge so the falling-edge logic never races the bench
   always @(posedge ref_clk) begin
      goQ <= go;
      stayQ <= stay;
   end
   // both lines are pulled up, so a released line reads high
   always @(negedge ref_clk) begin
      if (reset) begin
         bus_request_n <= 1'b1;
         grant_ack_n <= 1'b1;
         served <= 1'b0;
      end else if (!grant_ack_n) begin
         cnt <= cnt + 1;
         if (cnt == HOLD) begin
            grant_ack_n <= 1'b1; // ownership ends only by release
         end
         bus_request_n <= !(goQ && stayQ); // a held request is a second requester
      end else if (goQ && !served) begin
         bus_request_n <= 1'b0; // request first, then wait for grant
         if (!bus_grant_n) begin
            grant_ack_n <= 1'b0; // take the bus as soon as grant is seen
            bus_request_n <= !stayQ;
            served <= 1'b1;
            cnt <= 0;
         end
      end else if (!goQ) begin
         bus_request_n <= 1'b1;
         served <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ### tb/ext_bus_halt_and_arbiter_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ext_bus_halt_and_arbiter_tb
   import ebha_pkg::*;
;
   localparam logic [1:0] ACK_WORD = 2'h0;
   logic ref_clk = 0, reset = 1, haltIn_n = 1, bus_fault_in = 0, locked_cycle_n = 1;
   logic [1:0] transfer_ack_n = ACK_NONE, transfer_size = SIZE_WORD, show_cycle_enable = 2'h0;
   logic cycleReq = 0, excProcActive = 0, addrErrPulse = 0, go = 0, stay = 0;
   logic bus_request_n, grant_ack_n, bus_grant_n, haltOe_n, cycleStart, cycleDone, busErrExc;
   logic retryActive, strobeEnable, strobeOe_n, dataOe_n, addrOe_n, intAcceptEn, halted, doubleFault;
   logic st, ok;
   logic [2:0] res;
   int fails = 0, compares = 0, cycles = 0;

   ebha_bus_halt_arbiter u_dut (.ref_clk(ref_clk), .reset(reset), .haltIn_n(haltIn_n), .haltOut(),
      .haltOe_n(haltOe_n), .bus_fault_in(bus_fault_in), .transfer_ack_n(transfer_ack_n),
      .transfer_size(transfer_size), .locked_cycle_n(locked_cycle_n), .show_cycle_enable(show_cycle_enable),
      .bus_request_n(bus_request_n), .grant_ack_n(grant_ack_n), .bus_grant_n(bus_grant_n),
      .cycleReq(cycleReq), .excProcActive(excProcActive), .addrErrPulse(addrErrPulse),
      .cycleStart(cycleStart), .cycleDone(cycleDone), .busErrExc(busErrExc), .retryActive(retryActive),
      .strobeEnable(strobeEnable), .strobeOe_n(strobeOe_n), .dataOe_n(dataOe_n), .addrOe_n(addrOe_n),
      .intAcceptEn(intAcceptEn), .halted(halted), .doubleFault(doubleFault));
   ebha_ext_master u_far (.ref_clk(ref_clk), .reset(reset), .go(go), .stay(stay),
      .bus_grant_n(bus_grant_n), .bus_request_n(bus_request_n), .grant_ack_n(grant_ack_n));

   initial begin
      forever #12.5 ref_clk = ~ref_clk;
   end

   task close_out;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // a hang counts as a mismatch
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         fails = fails + 1;
         close_out;
      end
   end

   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      compares++;
      if (s !== e) begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask

   task automatic await_sig(input int sel, input int lim, output logic hit);
      hit = 0;
      for (int i = 0; i < lim && !hit; i++) begin
         @(negedge ref_clk);
         case (sel)
            0: hit = (cycleStart === 1'b1);
            1: hit = (bus_grant_n === 1'b0);
            2: hit = (bus_grant_n === 1'b1);
            3: hit = (addrOe_n === 1'b0);
            default: hit = (grant_ack_n === 1'b0);
         endcase
      end
   endtask

   task do_reset;
      reset = 1;
      cycleReq = 0;
      repeat (6) @(negedge ref_clk);
      reset = 0;
      repeat (3) @(negedge ref_clk);
   endtask

   // ack is held until the ending pulse shows, so it is always sampled
   task automatic run_cycle(input logic req, input logic [1:0] sz, input logic [1:0] ack, input logic flt,
         input int dly, input logic hAft, input int lim, output logic s, output logic [2:0] r);
      r = 3'h0;
      cycleReq = cycleReq | req;
      transfer_size = sz;
      await_sig(0, lim, s);
      if (s) begin
         cycleReq = 0;
         haltIn_n = hAft;
         chk(8'({strobeEnable, dataOe_n}), 8'h2);
         repeat (dly) begin
            @(negedge ref_clk);
            r = r | {cycleDone | !bus_grant_n, busErrExc, retryActive};
         end
         chk(8'(r), 8'h0); // no end and no grant while unacknowledged
         transfer_ack_n = ack;
         bus_fault_in = flt;
         for (int i = 0; i < 6 && r == 3'h0; i++) begin
            @(negedge ref_clk);
            r = {cycleDone, busErrExc, retryActive};
         end
         transfer_ack_n = ACK_NONE;
         bus_fault_in = 0;
      end
   endtask

   task automatic arb(input int lim, output logic got);
      logic h;
      go = 1;
      await_sig(1, lim, got);
      if (got) begin
         chk(8'(addrOe_n), 8'h1);
         await_sig(4, 6, h);
         await_sig(2, 8, h);
         chk(8'({h, addrOe_n}), 8'h3);
         go = 0;
         await_sig(3, 20, h);
         chk(8'({h, bus_grant_n, grant_ack_n}), 8'h7);
      end
   endtask

   task t_halt;
      run_cycle(1, SIZE_WORD, ACK_WORD, 0, 4, 0, 4, st, res);
      chk(8'({st, res}), 8'hC);
      @(negedge ref_clk);
      chk(8'({halted, intAcceptEn, dataOe_n, strobeEnable, strobeOe_n, addrOe_n}), 8'h28);
      arb(8, ok);
      chk(8'({ok, addrOe_n, halted}), 8'h5);
      run_cycle(1, SIZE_WORD, ACK_WORD, 0, 0, 0, 8, st, res);
      chk(8'(st), 8'h0);
      haltIn_n = 1;
      run_cycle(0, SIZE_WORD, ACK_WORD, 0, 0, 0, 8, st, res);
      chk(8'({st, res}), 8'hC);
      repeat (2) @(negedge ref_clk);
      run_cycle(1, SIZE_BYTE, ACK_WORD, 0, 0, 0, 8, st, res);
      chk(8'(st), 8'h0);
      haltIn_n = 1;
      run_cycle(0, SIZE_BYTE, ACK_WORD, 0, 0, 1, 8, st, res);
      chk(8'({st, res}), 8'hC);
   endtask

   task t_retry;
      run_cycle(1, SIZE_WORD, ACK_NONE, 1, 3, 0, 4, st, res);
      chk(8'({st, res}), 8'h9);
      excProcActive = 1;
      haltIn_n = 1;
      run_cycle(0, SIZE_WORD, ACK_NONE, 1, 3, 0, 8, st, res);
      chk(8'({st, res, doubleFault}), 8'h12);
      haltIn_n = 1;
      run_cycle(0, SIZE_WORD, ACK_WORD, 0, 0, 1, 8, st, res);
      excProcActive = 0;
      chk(8'({st, res}), 8'hC);
   endtask

   task t_fault;
      run_cycle(1, SIZE_WORD, ACK_NONE, 1, 0, 1, 4, st, res);
      chk(8'({res, doubleFault}), 8'h4);
      excProcActive = 1;
      addrErrPulse = 1;
      @(negedge ref_clk);
      addrErrPulse = 0;
      @(negedge ref_clk);
      excProcActive = 0;
      chk(8'({doubleFault, haltOe_n, halted}), 8'h5);
      run_cycle(1, SIZE_WORD, ACK_WORD, 0, 0, 1, 8, st, res);
      chk(8'(st), 8'h0);
      arb(8, ok);
      chk(8'(ok), 8'h1);
      do_reset;
      chk(8'({doubleFault, haltOe_n, halted}), 8'h2);
      excProcActive = 1;
      run_cycle(1, SIZE_WORD, ACK_NONE, 1, 0, 1, 4, st, res);
      excProcActive = 0;
      chk(8'({res, doubleFault}), 8'h5);
      do_reset;
      chk(8'({doubleFault, haltOe_n}), 8'h1);
   endtask

   task t_arb;
      go = 1;
      run_cycle(1, SIZE_WORD, ACK_WORD, 0, 4, 1, 4, st, res);
      arb(8, ok);
      chk(8'({st, res, ok}), 8'h19);
      run_cycle(1, SIZE_LONG, ACK_WORD, 0, 0, 1, 4, st, res);
      arb(8, ok);
      chk(8'(ok), 8'h0);
      run_cycle(1, SIZE_WORD, ACK_WORD, 0, 0, 1, 4, st, res);
      arb(8, ok);
      chk(8'(ok), 8'h1);
      locked_cycle_n = 0;
      arb(10, ok);
      chk(8'(ok), 8'h0);
      locked_cycle_n = 1;
      arb(8, ok);
      show_cycle_enable = SHOW_NO_GRANT;
      arb(10, ok);
      chk(8'(ok), 8'h0);
      show_cycle_enable = 2'h0;
      arb(8, ok);
      go = 1;
      @(negedge ref_clk);
      go = 0;
      repeat (8) @(negedge ref_clk);
      run_cycle(1, SIZE_WORD, ACK_WORD, 0, 0, 1, 4, st, res);
      chk(8'({st, res, addrOe_n}), 8'h18);
      stay = 1;
      go = 1;
      await_sig(1, 8, ok);
      await_sig(4, 6, ok);
      await_sig(2, 8, ok);
      await_sig(1, 10, ok);
      chk(8'({ok, grant_ack_n}), 8'h2);
      go = 0;
      stay = 0;
      await_sig(3, 24, ok);
      chk(8'({ok, bus_grant_n}), 8'h3);
   endtask

   initial begin
      do_reset;
      chk(8'({bus_grant_n, haltOe_n, doubleFault, halted, addrOe_n}), 8'h18);
      t_halt;
      t_retry;
      t_fault;
      t_arb;
      close_out;
   end
endmodule
`default_nettype wire
